//--- common/crsl_defines.svh
// reset, reinitialise and soft-init values of the architectural state
`ifndef CRSL_DEFINES_SVH
`define CRSL_DEFINES_SVH

// ----------------------------------------------------------------------
// system control word 0
// ----------------------------------------------------------------------
`define CRSL_CTL0_RST        32'h6000_0010
`define CRSL_CTL0_CACHE_OFF  30
`define CRSL_CTL0_WT_OFF     29
`define CRSL_CTL0_ONE_BIT    4
`define CRSL_CTL0_PROT_BIT   0
`define CRSL_CTL0_PAGE_BIT   31

// ----------------------------------------------------------------------
// integer state
// ----------------------------------------------------------------------
`define CRSL_IP_RST          32'h0000_FFF0
`define CRSL_FLAGS_RST       32'h0000_0002
`define CRSL_ZERO32          32'h0000_0000
`define CRSL_SELFTEST_FAIL   32'h0000_0001

// ----------------------------------------------------------------------
// segments
// ----------------------------------------------------------------------
`define CRSL_CODE_SEL_RST    16'hF000
`define CRSL_CODE_BASE_RST   32'hFFFF_0000
`define CRSL_DATA_SEL_RST    16'h0000
`define CRSL_DATA_BASE_RST   32'h0000_0000
`define CRSL_SEG_LIMIT_RST   16'hFFFF
`define CRSL_SEG_AR_RST      8'h93

// ----------------------------------------------------------------------
// floating-point unit
// ----------------------------------------------------------------------
`define CRSL_FCTL_RST        16'h0040
`define CRSL_FCTL_REINIT     16'h037F
`define CRSL_FTAG_RST        16'h5555
`define CRSL_FTAG_REINIT     16'hFFFF
`define CRSL_ZERO16          16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CRSL_SYNC_SETTLE     2'h2

`endif

//--- common/crsl_pkg.sv
// types shared by the reset state loader
package crsl_pkg;

	// 32-bit architectural registers, in array order
	typedef enum logic [3:0] {
		CRSL_SYS_CTL0, CRSL_FAULT_ADDR, CRSL_PAGE_BASE, CRSL_EXT_CTL,
		CRSL_INSTR_PTR, CRSL_FLAGS, CRSL_ACC, CRSL_BASE_GP, CRSL_COUNT_GP,
		CRSL_SRC_IDX, CRSL_DST_IDX, CRSL_FRAME_PTR, CRSL_STACK_PTR,
		CRSL_FP_DATA_PTR, CRSL_FP_INSTR_PTR
	} crsl_reg32_t;

	// 16-bit floating-point registers, in array order
	typedef enum logic [2:0] {
		CRSL_FP_CTL, CRSL_FP_STAT, CRSL_FP_TAG, CRSL_FP_DATA_SEL,
		CRSL_FP_CODE_SEL
	} crsl_reg16_t;

	// segments: code, stack, then four data segments
	typedef enum logic [2:0] {
		CRSL_SEG_CODE, CRSL_SEG_STACK, CRSL_SEG_DATA, CRSL_SEG_EXTRA,
		CRSL_SEG_EXTRA_F, CRSL_SEG_EXTRA_G
	} crsl_seg_t;

	typedef enum {
		CRSL_SETTLE,
		CRSL_SELFTEST,
		CRSL_RUN
	} crsl_phase_t;

endpackage

//--- verilog/crsl_fp_slots.sv
// eight-slot floating-point stack storage, cleared to +0.0 by reset
`timescale 1ns/10ps
`default_nettype none

module crsl_fp_slots #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     rstn,
	// write side
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	// read side
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data
);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("crsl_fp_slots: DEPTH must be a power of two");
	end

	logic [DEPTH-1:0][WIDTH-1:0] slot_q;
	logic [DEPTH-1:0][WIDTH-1:0] slot_d;
	logic [WIDTH-1:0]            rd_d;

	always_comb begin
		slot_d = slot_q;
		if (wr_en)
			slot_d[wr_addr] = wr_data;
		rd_d = slot_q[rd_addr];
	end

	// positive zero is the all-zero pattern
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			slot_q  <= '0;
			rd_data <= '0;
		end else begin
			slot_q  <= slot_d;
			rd_data <= rd_d;
		end
	end

endmodule // crsl_fp_slots

`default_nettype wire

//--- verilog/crsl_reset_loader.sv
// architectural register state with its reset, soft-init and fp reinit
`timescale 1ns/10ps
`default_nettype none

`include "crsl_defines.svh"

module crsl_reset_loader #(
	parameter int FP_WIDTH = 80,
	parameter int FP_DEPTH = 8
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rstn,
	// init events from the core, one-cycle pulses
	input  wire logic                        soft_init,
	input  wire logic                        fp_reinit_instruction,
	// self-test strap pin and result from the test engine
	input  wire logic                        power_on_selftest,
	input  wire logic                        selftest_done,
	input  wire logic                        selftest_pass,
	// 32-bit register write
	input  wire logic                        wr32_en,
	input  wire crsl_pkg::crsl_reg32_t       wr32_sel,
	input  wire logic [31:0]                 wr32_data,
	// 16-bit fp register write
	input  wire logic                        wr16_en,
	input  wire crsl_pkg::crsl_reg16_t       wr16_sel,
	input  wire logic [15:0]                 wr16_data,
	// segment write
	input  wire logic                        seg_wr_en,
	input  wire crsl_pkg::crsl_seg_t         seg_wr_sel,
	input  wire logic [15:0]                 seg_wr_selector,
	input  wire logic [31:0]                 seg_wr_base,
	input  wire logic [15:0]                 seg_wr_limit,
	input  wire logic [7:0]                  seg_wr_attr,
	// fp stack slot access
	input  wire logic                        fp_wr_en,
	input  wire logic [$clog2(FP_DEPTH)-1:0] fp_wr_addr,
	input  wire logic [FP_WIDTH-1:0]         fp_wr_data,
	input  wire logic [$clog2(FP_DEPTH)-1:0] fp_rd_addr,
	output logic      [FP_WIDTH-1:0]         fp_stack_slots,
	// register contents
	output logic      [14:0][31:0]           reg32,
	output logic      [4:0][15:0]            reg16,
	output logic      [5:0][15:0]            seg_selector,
	output logic      [5:0][31:0]            seg_base,
	output logic      [5:0][15:0]            seg_limit,
	output logic      [5:0][7:0]             seg_attr,
	// mode and sequencing status
	output logic                             real_mode,
	output logic                             paging_on,
	output logic                             fetch_ok
);

	if (FP_DEPTH != 8) begin : g_bad_depth
		$error("crsl_reset_loader: fp stack must have eight slots");
	end

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	function automatic logic [31:0] rst32(input int idx);
		case (idx)
			int'(crsl_pkg::CRSL_SYS_CTL0):  rst32 = `CRSL_CTL0_RST;
			int'(crsl_pkg::CRSL_INSTR_PTR): rst32 = `CRSL_IP_RST;
			// undefined upper flag bits are simply loaded as zero
			int'(crsl_pkg::CRSL_FLAGS):     rst32 = `CRSL_FLAGS_RST;
			default:                        rst32 = `CRSL_ZERO32;
		endcase
	endfunction

	function automatic logic [15:0] fp16_val(input int idx, input logic ri);
		case (idx)
			int'(crsl_pkg::CRSL_FP_CTL):
				fp16_val = ri ? `CRSL_FCTL_REINIT : `CRSL_FCTL_RST;
			int'(crsl_pkg::CRSL_FP_TAG):
				fp16_val = ri ? `CRSL_FTAG_REINIT : `CRSL_FTAG_RST;
			default: fp16_val = `CRSL_ZERO16;
		endcase
	endfunction

	function automatic logic is_fp32(input int idx);
		is_fp32 = idx == int'(crsl_pkg::CRSL_FP_DATA_PTR) ||
			idx == int'(crsl_pkg::CRSL_FP_INSTR_PTR);
	endfunction

	// ------------------------------------------------------------------
	// strap synchroniser and phase
	// ------------------------------------------------------------------
	logic                  strap_meta_q;
	logic                  strap_q;
	logic [1:0]            settle_q;
	logic [1:0]            settle_d;
	crsl_pkg::crsl_phase_t phase_q;
	crsl_pkg::crsl_phase_t phase_d;
	logic                  st_load;

	always_comb begin
		settle_d = settle_q;
		phase_d  = phase_q;
		st_load  = 1'b0;
		case (phase_q)
			crsl_pkg::CRSL_SETTLE: begin
				// wait for the strap to pass both synchroniser stages
				if (settle_q == `CRSL_SYNC_SETTLE)
					phase_d = strap_q ? crsl_pkg::CRSL_SELFTEST
						: crsl_pkg::CRSL_RUN;
				else
					settle_d = settle_q + 2'h1;
			end
			crsl_pkg::CRSL_SELFTEST: begin
				if (selftest_done) begin
					st_load = 1'b1;
					phase_d = crsl_pkg::CRSL_RUN;
				end
			end
			crsl_pkg::CRSL_RUN: phase_d = crsl_pkg::CRSL_RUN;
			default: phase_d = crsl_pkg::CRSL_SETTLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			strap_meta_q <= 1'b0;
			strap_q      <= 1'b0;
			settle_q     <= 2'h0;
			phase_q      <= crsl_pkg::CRSL_SETTLE;
		end else begin
			strap_meta_q <= power_on_selftest;
			strap_q      <= strap_meta_q;
			settle_q     <= settle_d;
			phase_q      <= phase_d;
		end
	end

	// fetch waits until every load, self-test result included, is done
	assign fetch_ok = phase_q == crsl_pkg::CRSL_RUN;

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [14:0][31:0] r32_d;
	logic [4:0][15:0]  r16_d;
	logic [5:0][15:0]  sel_d;
	logic [5:0][31:0]  base_d;
	logic [5:0][15:0]  lim_d;
	logic [5:0][7:0]   ar_d;
	logic              run;
	logic [31:0]       ctl0_keep;

	assign run = phase_q == crsl_pkg::CRSL_RUN;

	always_comb begin
		r32_d  = reg32;
		r16_d  = reg16;
		sel_d  = seg_selector;
		base_d = seg_base;
		lim_d  = seg_limit;
		ar_d   = seg_attr;
		ctl0_keep = `CRSL_ZERO32;
		ctl0_keep[`CRSL_CTL0_CACHE_OFF] =
			reg32[crsl_pkg::CRSL_SYS_CTL0][`CRSL_CTL0_CACHE_OFF];
		ctl0_keep[`CRSL_CTL0_WT_OFF] =
			reg32[crsl_pkg::CRSL_SYS_CTL0][`CRSL_CTL0_WT_OFF];
		ctl0_keep[`CRSL_CTL0_ONE_BIT] = 1'b1;
		// writes are refused until the reset sequence is over
		if (run && soft_init) begin
			for (int i = 0; i < 15; i++) begin
				if (!is_fp32(i))
					r32_d[i] = rst32(i);
			end
			r32_d[crsl_pkg::CRSL_SYS_CTL0] = ctl0_keep;
			for (int s = 0; s < 6; s++) begin
				sel_d[s]  = s == 0 ? `CRSL_CODE_SEL_RST : `CRSL_DATA_SEL_RST;
				base_d[s] = s == 0 ? `CRSL_CODE_BASE_RST : `CRSL_DATA_BASE_RST;
				lim_d[s]  = `CRSL_SEG_LIMIT_RST;
				ar_d[s]   = `CRSL_SEG_AR_RST;
			end
		end else if (run && fp_reinit_instruction) begin
			for (int j = 0; j < 5; j++)
				r16_d[j] = fp16_val(j, 1'b1);
			r32_d[crsl_pkg::CRSL_FP_DATA_PTR]  = `CRSL_ZERO32;
			r32_d[crsl_pkg::CRSL_FP_INSTR_PTR] = `CRSL_ZERO32;
		end else if (run) begin
			if (wr32_en)
				r32_d[wr32_sel] = wr32_data;
			if (wr16_en)
				r16_d[wr16_sel] = wr16_data;
			if (seg_wr_en) begin
				sel_d[seg_wr_sel]  = seg_wr_selector;
				base_d[seg_wr_sel] = seg_wr_base;
				lim_d[seg_wr_sel]  = seg_wr_limit;
				ar_d[seg_wr_sel]   = seg_wr_attr;
			end
		end
		if (st_load)
			r32_d[crsl_pkg::CRSL_ACC] = selftest_pass ? `CRSL_ZERO32
				: `CRSL_SELFTEST_FAIL;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 15; i++)
				reg32[i] <= rst32(i);
			for (int j = 0; j < 5; j++)
				reg16[j] <= fp16_val(j, 1'b0);
			for (int s = 0; s < 6; s++) begin
				seg_selector[s] <= s == 0 ? `CRSL_CODE_SEL_RST
					: `CRSL_DATA_SEL_RST;
				seg_base[s] <= s == 0 ? `CRSL_CODE_BASE_RST
					: `CRSL_DATA_BASE_RST;
				seg_limit[s] <= `CRSL_SEG_LIMIT_RST;
				seg_attr[s]  <= `CRSL_SEG_AR_RST;
			end
		end else begin
			reg32        <= r32_d;
			reg16        <= r16_d;
			seg_selector <= sel_d;
			seg_base     <= base_d;
			seg_limit    <= lim_d;
			seg_attr     <= ar_d;
		end
	end

	assign real_mode =
		~reg32[crsl_pkg::CRSL_SYS_CTL0][`CRSL_CTL0_PROT_BIT];
	assign paging_on =
		reg32[crsl_pkg::CRSL_SYS_CTL0][`CRSL_CTL0_PAGE_BIT];

	// ------------------------------------------------------------------
	// fp stack slots
	// ------------------------------------------------------------------
	// neither soft init nor fp reinit reaches the slots
	crsl_fp_slots #(
		.WIDTH (FP_WIDTH),
		.DEPTH (FP_DEPTH)
	) u_slots (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (fp_wr_en && run),
		.wr_addr (fp_wr_addr),
		.wr_data (fp_wr_data),
		.rd_addr (fp_rd_addr),
		.rd_data (fp_stack_slots)
	);

endmodule // crsl_reset_loader

`default_nettype wire

//--- testbench/crsl_reset_loader_chk.sv
// concurrent checks on the reset state loader ports
`timescale 1ns/10ps
`default_nettype none

module crsl_reset_loader_chk #(
	parameter int FP_WIDTH = 80
) (
	// clock and reset
	input wire logic                clock,
	input wire logic                rstn,
	// events
	input wire logic                soft_init,
	input wire logic                fp_reinit_instruction,
	input wire logic                power_on_selftest,
	input wire logic                selftest_done,
	input wire logic                selftest_pass,
	// state
	input wire logic [FP_WIDTH-1:0] fp_stack_slots,
	input wire logic [14:0][31:0]   reg32,
	input wire logic [4:0][15:0]    reg16,
	input wire logic [5:0][15:0]    seg_selector,
	input wire logic [5:0][31:0]    seg_base,
	input wire logic [5:0][15:0]    seg_limit,
	input wire logic [5:0][7:0]     seg_attr,
	input wire logic                real_mode,
	input wire logic                paging_on,
	input wire logic                fetch_ok
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	// ----------
	// properties
	// ----------
	sequence rel_s; $rose(rstn); endsequence
	sequence settle_s; !fetch_ok [*3] ##1 fetch_ok; endsequence
	sequence soft_s; fetch_ok && soft_init; endsequence

	ctl0_reset_a: assert property (rel_s |->
		reg32[0] == 32'h6000_0010)
		else $error("control word wrong after reset");
	ip_flags_a: assert property (rel_s |->
		reg32[4] == 32'h0000_FFF0 && reg32[5][21:0] == 22'h2)
		else $error("pointer or flags wrong after reset");
	gp_clear_a: assert property (rel_s |->
		reg32[3:1] == '0 && reg32[12:6] == '0)
		else $error("general registers not cleared");
	seg_reset_a: assert property (rel_s |->
		seg_selector == 96'hF000 && seg_base == 192'hFFFF_0000 &&
		seg_limit == {6{16'hFFFF}} && seg_attr == {6{8'h93}})
		else $error("segments wrong after reset");
	fp_reset_a: assert property (rel_s |->
		reg16 == 80'h5555_0000_0040 && reg32[14:13] == '0 &&
		fp_stack_slots == '0)
		else $error("fp state wrong after reset");
	mode_dec_a: assert property (
		real_mode == !reg32[0][0] && paging_on == reg32[0][31])
		else $error("mode flags disagree with control word");
	fetch_gate_a: assert property (
		rel_s ##0 !power_on_selftest |-> settle_s)
		else $error("fetch enable timing wrong");
	refuse_hold_a: assert property (
		!fetch_ok |=> reg16 == $past(reg16))
		else $error("fp word changed before fetch");
	reinit_vals_a: assert property (
		fetch_ok && fp_reinit_instruction && !soft_init |=>
		reg16 == 80'hFFFF_0000_037F && reg32[14:13] == '0)
		else $error("reinit values wrong");
	soft_ctl0_a: assert property (soft_s |=>
		reg32[0] == (($past(reg32[0]) & 32'h6000_0000) | 32'h0000_0010))
		else $error("soft init control word wrong");
	soft_fp_a: assert property (soft_s |=>
		reg16 == $past(reg16) && reg32[14:13] == $past(reg32[14:13]))
		else $error("soft init touched fp state");
	selftest_res_a: assert property (
		!fetch_ok && selftest_done |=>
		fetch_ok && reg32[6] == {31'h0, !$past(selftest_pass)})
		else $error("self-test result wrong");
endmodule // crsl_reset_loader_chk

bind crsl_reset_loader crsl_reset_loader_chk #(.FP_WIDTH(FP_WIDTH)) u_chk (.*);

`default_nettype wire

//--- testbench/crsl_reset_loader_tb.sv
// self-checking bench for the reset state loader
`timescale 1ns/10ps
`default_nettype none

module crsl_reset_loader_tb;
	logic                  clock, rstn, soft_init, fp_reinit_instruction;
	logic                  power_on_selftest, selftest_done, selftest_pass;
	logic                  wr32_en, wr16_en, seg_wr_en, fp_wr_en;
	crsl_pkg::crsl_reg32_t wr32_sel;
	crsl_pkg::crsl_reg16_t wr16_sel;
	crsl_pkg::crsl_seg_t   seg_wr_sel;
	logic [31:0]           wr32_data, seg_wr_base;
	logic [15:0]           wr16_data, seg_wr_selector, seg_wr_limit;
	logic [7:0]            seg_wr_attr;
	logic [2:0]            fp_wr_addr, fp_rd_addr;
	logic [79:0]           fp_wr_data, fp_stack_slots;
	logic [14:0][31:0]     reg32;
	logic [4:0][15:0]      reg16;
	logic [5:0][15:0]      seg_selector, seg_limit;
	logic [5:0][31:0]      seg_base;
	logic [5:0][7:0]       seg_attr;
	logic                  real_mode, paging_on, fetch_ok;
	int                    err_count, samples_checked;

	crsl_reset_loader dut (.*);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// -----
	// tasks
	// -----
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [191:0] got, exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	task automatic do_reset(input logic strap);
		int n;
		@(posedge clock);
		rstn <= 1'b0;
		power_on_selftest <= strap;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		#1;
		// bounded: the settle count is short
		for (n = 0; !strap && fetch_ok !== 1'b1; n++) begin
			@(posedge clock);
			#1;
			if (n > 20) begin
				check(1'b0, 1'b1, "fetch enable never rose");
				complete_run();
			end
		end
	endtask

	task automatic w32(input int i, input logic [31:0] d);
		@(posedge clock);
		wr32_en <= 1'b1;
		wr32_sel <= crsl_pkg::crsl_reg32_t'(i);
		wr32_data <= d;
		@(posedge clock);
		wr32_en <= 1'b0;
		#1;
		check(reg32[i], d, "register write");
	endtask

	task automatic w16(input int i, input logic [15:0] d);
		@(posedge clock);
		wr16_en <= 1'b1;
		wr16_sel <= crsl_pkg::crsl_reg16_t'(i);
		wr16_data <= d;
		@(posedge clock);
		wr16_en <= 1'b0;
		#1;
		check(reg16[i], d, "fp word write");
	endtask

	task automatic ev(input logic s, input logic r);
		@(posedge clock);
		soft_init <= s;
		fp_reinit_instruction <= r;
		@(posedge clock);
		soft_init <= 1'b0;
		fp_reinit_instruction <= 1'b0;
		#1;
	endtask

	task automatic wslot(input logic [2:0] a, input logic [79:0] d);
		@(posedge clock);
		fp_wr_en <= 1'b1;
		fp_wr_addr <= a;
		fp_wr_data <= d;
		@(posedge clock);
		fp_wr_en <= 1'b0;
	endtask

	task automatic slot(input logic [2:0] a, input logic [79:0] e);
		@(posedge clock);
		fp_rd_addr <= a;
		@(posedge clock);
		#1;
		check(fp_stack_slots, e, "stack slot");
	endtask

	// ---------
	// scenarios
	// ---------
	task automatic t_reset;
		logic [31:0] m, e;
		for (int i = 0; i < 15; i++) begin
			m = (i == 5) ? 32'h003F_FFFF : 32'hFFFF_FFFF;
			e = (i == 0) ? 32'h6000_0010 : (i == 4) ? 32'h0000_FFF0 : 32'h0;
			e = (i == 5) ? 32'h0000_0002 : e;
			check(reg32[i] & m, e, "reset register");
		end
		check(reg16, 80'h5555_0000_0040, "fp words");
		check(seg_selector, 96'hF000, "selectors");
		check(seg_base, 192'hFFFF_0000, "bases");
		check({seg_limit, seg_attr}, {{6{16'hFFFF}}, {6{8'h93}}}, "limits");
		check({real_mode, paging_on}, 2'b10, "mode");
		for (int a = 0; a < 8; a++) slot(3'(a), 80'h0);
	endtask

	task automatic t_soft;
		w32(0, 32'hFFFF_FFFF);
		w32(6, 32'h1234_5678);
		w32(13, 32'h0000_0ABC);
		w16(0, 16'h1111);
		wslot(3'h3, 80'h1);
		@(posedge clock);
		seg_wr_en <= 1'b1;
		seg_wr_selector <= 16'h1234;
		@(posedge clock);
		seg_wr_en <= 1'b0;
		#1;
		check(seg_selector[0], 16'h1234, "segment write");
		ev(1'b1, 1'b0);
		check(reg32[0], 32'h6000_0010, "soft control word");
		check(reg32[6], 32'h0, "soft accumulator");
		check(seg_selector, 96'hF000, "soft selectors");
		check({seg_base[0], seg_limit[0], seg_attr[0]},
			{32'hFFFF_0000, 16'hFFFF, 8'h93}, "soft code segment");
		check({reg32[13], reg16[0]}, 48'h0ABC_1111, "soft fp kept");
		slot(3'h3, 80'h1);
		w32(0, 32'h0);
		ev(1'b1, 1'b0);
		check(reg32[0], 32'h0000_0010, "soft cleared control");
	endtask

	task automatic t_reinit;
		w16(2, 16'h3333);
		w16(4, 16'h4444);
		w32(14, 32'h5555_0000);
		wslot(3'h5, 80'h2);
		ev(1'b1, 1'b1);
		check(reg16[2], 16'h3333, "soft over reinit");
		ev(1'b0, 1'b1);
		check(reg16, 80'hFFFF_0000_037F, "reinit words");
		check(reg32[14:13], 64'h0, "reinit pointers");
		slot(3'h5, 80'h2);
	endtask

	task automatic t_selftest(input logic p);
		do_reset(1'b1);
		@(posedge clock);
		wr16_en <= 1'b1;
		wr16_sel <= crsl_pkg::CRSL_FP_CTL;
		wr16_data <= 16'hABCD;
		repeat (6) @(posedge clock);
		#1;
		check(fetch_ok, 1'b0, "fetch before result");
		@(posedge clock);
		selftest_done <= 1'b1;
		selftest_pass <= p;
		wr16_en <= 1'b0;
		@(posedge clock);
		selftest_done <= 1'b0;
		#1;
		check({fetch_ok, reg32[6]}, {1'b1, 31'h0, !p}, "test result");
		check(reg16[0], 16'h0040, "early write");
	endtask

	initial begin
		{rstn, soft_init, fp_reinit_instruction, power_on_selftest} = '0;
		{selftest_done, selftest_pass, wr32_en, wr16_en} = '0;
		{seg_wr_en, fp_wr_en, fp_wr_addr, fp_rd_addr, fp_wr_data} = '0;
		{wr32_data, seg_wr_base, wr16_data, seg_wr_selector} = '0;
		{seg_wr_limit, seg_wr_attr, err_count, samples_checked} = '0;
		wr32_sel = crsl_pkg::CRSL_SYS_CTL0;
		wr16_sel = crsl_pkg::CRSL_FP_CTL;
		seg_wr_sel = crsl_pkg::CRSL_SEG_CODE;
		do_reset(1'b0);
		t_reset();
		t_soft();
		t_reinit();
		t_selftest(1'b0);
		t_selftest(1'b1);
		do_reset(1'b0);
		t_reset();
		complete_run();
	end
endmodule // crsl_reset_loader_tb

`default_nettype wire
